// ### rtl/bmd_decode.sv
// Purpose: Board glue between a controller's external memory bus and an external RAM.
// Assumes: All inputs synchronous to core_clk_in; the controller clock output is sampled for edges.
// Notes:   RAM selects are combinational; indicators are set-reset registers updated on controller clock rising edges.
// Notes on behaviour
// - Switches 00: RAM enables both high, external access select low.
// - Switches 01: RAM chip enable low exactly when address bit 15 high.
// - Modes other than 00: output enable low when either strobe low.
// - Switches 11: RAM chip enable low for every address, external select low.
// - Switches 10: RAM chip enable always low, external access select high.
// - Decode vector is address 15..11 then read strobe, six bits.
// - Latch 0 set on 100000, cleared on 100010.
// - Latch 1 set on 100100, cleared on 100110.
// - Latch 2 set on 101000, cleared on 101010.
// - Latch 3 set on 101100, cleared on 101110.
// - Indicators are set-reset registers updated on controller clock rising edges.

`default_nettype none

module bmd_decode
  import bmd_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Configuration switches.
  input  wire logic       config_switch_high_in,
  input  wire logic       config_switch_low_in,
  // Controller memory bus.
  input  wire logic [4:0] addr_hi_in,
  input  wire logic       read_strobe_n_in,
  input  wire logic       program_store_strobe_n_in,
  input  wire logic       controller_clock_output_in,
  // RAM and controller controls.
  output logic            ram_chip_enable_n_out,
  output logic            ram_output_enable_n_out,
  output logic            external_access_select_out,
  // Indicators.
  output logic [3:0]      indicator_latch_out
);

  logic [BMD_RST_SYNC-1:0] rst_sync_q;
  logic                    rst_n;
  logic                    ctl_clk_q;
  logic                    ctl_rise;
  logic [BMD_DEC_W-1:0]    dec_vec;
  logic [3:0]              ind_q;
  logic [3:0]              set_hit;
  logic [3:0]              clr_hit;
  bmd_map_t                map_sel;

  // Pattern of latch k, used for both set and clear matching.
  function automatic logic [5:0] bmd_pat(input logic [5:0] base, input int unsigned idx);
    logic [5:0] ofs;
    ofs = 6'(idx * BMD_IND_STEP);
    return base + ofs;
  endfunction

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[BMD_RST_SYNC-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[BMD_RST_SYNC-1];

  // Remembers the controller clock level so its rising edge can be found.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctl_clk_q <= 1'b0;
    end else begin
      ctl_clk_q <= controller_clock_output_in;
    end
  end
  assign ctl_rise = controller_clock_output_in & ~ctl_clk_q;

  // Decode vector: upper address bits then the read strobe; program strobe left out.
  assign dec_vec = {addr_hi_in, read_strobe_n_in};

  // Set and clear matches for each latch.
  genvar gi;
  generate
    for (gi = 0; gi < BMD_NUM_IND; gi++) begin : g_match
      assign set_hit[gi] = (dec_vec == bmd_pat(BMD_SET_BASE, gi));
      assign clr_hit[gi] = (dec_vec == bmd_pat(BMD_CLR_BASE, gi));
    end
  endgenerate

  // Set-reset latches updated only on a controller clock edge; otherwise they hold.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ind_q <= BMD_IND_RST;
    end else if (ctl_rise) begin
      ind_q <= (ind_q | set_hit) & ~clr_hit;
    end
  end
  assign indicator_latch_out = ind_q;

  // Memory map decode of the RAM selects and external access line.
  assign map_sel = bmd_map_t'({config_switch_high_in, config_switch_low_in});
  always_comb begin
    ram_chip_enable_n_out      = 1'b1;
    ram_output_enable_n_out    = 1'b1;
    external_access_select_out = 1'b0;
    case (map_sel)
      BMD_MAP_NONE: begin
        ram_chip_enable_n_out = 1'b1;
      end
      BMD_MAP_UPPER: begin
        ram_chip_enable_n_out   = ~addr_hi_in[4];
        ram_output_enable_n_out = read_strobe_n_in & program_store_strobe_n_in;
      end
      BMD_MAP_FULL: begin
        ram_chip_enable_n_out   = 1'b0;
        ram_output_enable_n_out = read_strobe_n_in & program_store_strobe_n_in;
      end
      BMD_MAP_EXTPG: begin
        ram_chip_enable_n_out      = 1'b0;
        ram_output_enable_n_out    = read_strobe_n_in & program_store_strobe_n_in;
        external_access_select_out = 1'b1;
      end
      default: begin
        ram_chip_enable_n_out = 1'b1;
      end
    endcase
  end

  // Checks on the memory map selects.
  // These outputs are combinational, so each is judged in the very cycle that it is sampled.

  // Mode 00 keeps the RAM off and all fetches internal.
  mode_none_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel == BMD_MAP_NONE) |-> (ram_chip_enable_n_out && ram_output_enable_n_out && !external_access_select_out))
    else $error("Mode 00 drives memory selects.");

  // Mode 00 ignores a read strobe on the RAM output enable.
  none_strobe_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel == BMD_MAP_NONE && !read_strobe_n_in) |-> ram_output_enable_n_out)
    else $error("Mode 00 output enable follows the read strobe.");

  // The upper map selects the RAM by address bit 15 alone.
  upper_ce_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel == BMD_MAP_UPPER) |-> (ram_chip_enable_n_out == !addr_hi_in[4]) && !external_access_select_out)
    else $error("Upper map chip enable wrong.");

  // The lower half stays free in the upper map.
  upper_low_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel == BMD_MAP_UPPER && !addr_hi_in[4]) |-> ram_chip_enable_n_out)
    else $error("Upper map selects RAM in the lower half.");

  // The output enable is the combined strobe in every map but 00.
  strobe_oe_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel != BMD_MAP_NONE) |-> (ram_output_enable_n_out == (read_strobe_n_in && program_store_strobe_n_in)))
    else $error("Output enable does not follow strobes.");

  // A program fetch alone opens the RAM output.
  oe_psen_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel != BMD_MAP_NONE && !program_store_strobe_n_in) |-> !ram_output_enable_n_out)
    else $error("Program strobe does not enable RAM output.");

  // A data read alone opens the RAM output.
  oe_read_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel != BMD_MAP_NONE && !read_strobe_n_in) |-> !ram_output_enable_n_out)
    else $error("Read strobe does not enable RAM output.");

  // With both strobes idle the RAM output stays closed.
  oe_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel != BMD_MAP_NONE && read_strobe_n_in && program_store_strobe_n_in) |-> ram_output_enable_n_out)
    else $error("RAM output enabled with strobes idle.");

  // The full map selects the RAM everywhere.
  full_ce_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel == BMD_MAP_FULL) |-> (!ram_chip_enable_n_out && !external_access_select_out))
    else $error("Full map selects wrong.");

  // The external program map selects the RAM and forces external fetch.
  extpg_ea_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (map_sel == BMD_MAP_EXTPG) |-> (!ram_chip_enable_n_out && external_access_select_out))
    else $error("External program map selects wrong.");

  // External access is never raised outside switch setting 10.
  ea_only_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    external_access_select_out |-> (map_sel == BMD_MAP_EXTPG))
    else $error("External access raised in the wrong map.");

  // Checks on the indicator latches.
  // A latch moves at the detected controller clock edge, so each result is looked at one core cycle later.

  // Reads with address bit 15 low match no pattern.
  low_half_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && !addr_hi_in[4]) |=> $stable(indicator_latch_out))
    else $error("Latches moved on a lower half read.");

  // Latch 0 set pattern.
  latch0_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h20) |=> indicator_latch_out[0])
    else $error("Latch 0 not set.");

  // Latch 0 clear pattern.
  latch0_clr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h22) |=> !indicator_latch_out[0])
    else $error("Latch 0 not cleared.");

  // Latch 1 set pattern.
  latch1_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h24) |=> indicator_latch_out[1])
    else $error("Latch 1 not set.");

  // Latch 1 clear pattern.
  latch1_clr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h26) |=> !indicator_latch_out[1])
    else $error("Latch 1 not cleared.");

  // Latch 2 set pattern.
  latch2_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h28) |=> indicator_latch_out[2])
    else $error("Latch 2 not set.");

  // Latch 2 clear pattern.
  latch2_clr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h2a) |=> !indicator_latch_out[2])
    else $error("Latch 2 not cleared.");

  // Latch 3 set pattern.
  latch3_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h2c) |=> indicator_latch_out[3])
    else $error("Latch 3 not set.");

  // Latch 3 clear pattern.
  latch3_clr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h2e) |=> !indicator_latch_out[3])
    else $error("Latch 3 not cleared.");

  // Indicators sit at their reset value while reset is held.
  reset_ind_a: assert property (@(posedge core_clk_in)
    !rst_n |-> (indicator_latch_out == BMD_IND_RST))
    else $error("Indicators not cleared by reset.");

  // A read with the strobe idle matches nothing.
  no_match_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && read_strobe_n_in) |=> $stable(indicator_latch_out))
    else $error("Latches moved without a read.");

  // A controller clock that stays high gives no second update.
  ctl_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (controller_clock_output_in && $past(controller_clock_output_in)) |=> $stable(indicator_latch_out))
    else $error("Latches moved while the controller clock stayed high.");

  // A low controller clock never updates the latches.
  ctl_low_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !controller_clock_output_in |=> $stable(indicator_latch_out))
    else $error("Latches moved while the controller clock was low.");

  // Without an edge every latch holds.
  latch_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !ctl_rise |=> $stable(indicator_latch_out))
    else $error("Latches moved without a clock edge.");

  // A program fetch alone leaves the latches alone.
  psen_ignore_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && read_strobe_n_in && !program_store_strobe_n_in) |=> $stable(indicator_latch_out))
    else $error("Program strobe moved a latch.");

  // Setting latch 1 leaves the other three as they were.
  latch_other_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h24) |=>
      ({indicator_latch_out[3:2], indicator_latch_out[0]} == $past({indicator_latch_out[3:2], indicator_latch_out[0]})))
    else $error("Setting latch 1 moved another latch.");

  // Clearing latch 0 leaves the other three as they were.
  clr_other_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (ctl_rise && {addr_hi_in, read_strobe_n_in} == 6'h22) |=> (indicator_latch_out[3:1] == $past(indicator_latch_out[3:1])))
    else $error("Clearing latch 0 moved another latch.");

  // Main scenarios.

  // External program fetch in progress.
  cov_extpg_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    map_sel == BMD_MAP_EXTPG && !program_store_strobe_n_in);

  // A read in the upper half with the upper map.
  cov_upper_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    map_sel == BMD_MAP_UPPER && addr_hi_in[4] && !read_strobe_n_in);

  // Latch 3 set on a controller clock edge.
  cov_set_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    ctl_rise && set_hit[3]);

  // A program fetch at a set address on a controller clock edge.
  cov_psen_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    ctl_rise && !program_store_strobe_n_in && addr_hi_in == 5'h10);

  // Latch 0 set and later cleared.
  cov_clr_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    indicator_latch_out[0] ##[1:20] !indicator_latch_out[0]);

endmodule

`default_nettype wire

// ### rtl/bmd_pkg.sv
// Purpose: Shared constants for the board memory decode and indicator latch block.
// Assumes: One 10 MHz core clock; the controller clock output arrives as a synchronous input.
// Notes:   Decode patterns are six bits: address bits 15..11 followed by the read strobe (active low).

`default_nettype none

package bmd_pkg;

  // Memory map selections from the two configuration switches.
  typedef enum logic [1:0] {
    BMD_MAP_NONE  = 2'h0,
    BMD_MAP_UPPER = 2'h1,
    BMD_MAP_EXTPG = 2'h2,
    BMD_MAP_FULL  = 2'h3
  } bmd_map_t;

  // Number of indicator latches and width of the decode vector.
  localparam int unsigned BMD_NUM_IND  = 4;
  localparam int unsigned BMD_DEC_W    = 6;

  // Base set and clear patterns; latch k adds k times the latch step.
  localparam logic [5:0]  BMD_SET_BASE = 6'h20;
  localparam logic [5:0]  BMD_CLR_BASE = 6'h22;
  localparam logic [5:0]  BMD_IND_STEP = 6'h04;

  // Reset value of the indicator latches.
  localparam logic [3:0]  BMD_IND_RST  = 4'h0;

  // Length of the reset release synchroniser.
  localparam int unsigned BMD_RST_SYNC = 2;

endpackage

`default_nettype wire

// ### test/bmd_ctrl_model.sv
// Purpose: Controller clock output model for the decode bench.
// Assumes: The core clock drives the model; the controller clock runs free.
// Notes:   Period is four core cycles; it changes on the falling core edge.
`default_nettype none
module bmd_ctrl_model (
  // Clock input.
  input  wire logic core_clk_in,
  // Controller clock output.
  output var logic  ctl_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  // Each phase lasts two core cycles, so the design samples both levels.
  always @(negedge core_clk_in) begin
    div_q       <= div_q + 2'h1;
    ctl_clk_out <= div_q[1];
  end
endmodule
`default_nettype wire

// ### test/tb_bmd_decode.sv
// Purpose: Self-checking bench for the memory decode and indicator block.
// Assumes: Inputs change on the falling core edge; the controller clock runs free.
// Notes:   Expected values are worked out here from the memory maps and patterns.
`default_nettype none
module tb_bmd_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, sw_hi, sw_lo, rd_n, psen_n, ctl, ce_n, oe_n, ea;
  logic [4:0] addr;
  logic [3:0] ind;
  int         fails = 0;
  int         comparisons = 0;
  bmd_ctrl_model bmd_ctrl_model_i (.core_clk_in(clk), .ctl_clk_out(ctl));
  bmd_decode bmd_decode_i (.core_clk_in(clk), .reset_n_in(rst_n), .config_switch_high_in(sw_hi),
    .config_switch_low_in(sw_lo), .addr_hi_in(addr), .read_strobe_n_in(rd_n),
    .program_store_strobe_n_in(psen_n), .controller_clock_output_in(ctl),
    .ram_chip_enable_n_out(ce_n), .ram_output_enable_n_out(oe_n),
    .external_access_select_out(ea), .indicator_latch_out(ind));
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Holds one bus state across a controller clock rising edge.
  task automatic bus_cycle(input logic [4:0] a, input logic r, input logic p);
    @(negedge clk);
    addr = a;
    rd_n = r;
    psen_n = p;
    @(posedge ctl);
    @(posedge clk);
    @(negedge clk);
  endtask
  // Sets each latch in turn, with ignored cycles between, then clears them all.
  task automatic test_latches();
    logic [3:0] exp;
    exp = 4'h0;
    for (int k = 0; k < 4; k++) begin
      bus_cycle(5'h10 + 5'(2 * k), 1'b1, 1'b0);
      check("program strobe at set address", exp, ind);
      bus_cycle(5'h10 + 5'(2 * k), 1'b0, 1'b1);
      exp[k] = 1'b1;
      check("read at set address", exp, ind);
    end
    bus_cycle(5'h18, 1'b0, 1'b1);
    check("read at unmatched address", exp, ind);
    for (int k = 0; k < 4; k++) begin
      bus_cycle(5'h11 + 5'(2 * k), 1'b0, 1'b1);
      exp[k] = 1'b0;
      check("read at clear address", exp, ind);
    end
  endtask
  // Walks every switch setting against address bit 15 and both strobes.
  task automatic test_maps();
    logic       e_ce, e_oe, e_ea;
    logic [4:0] v;
    for (int i = 0; i < 32; i++) begin
      v = 5'(i);
      @(negedge clk);
      {sw_hi, sw_lo, addr[4], rd_n, psen_n} = v;
      #10;
      e_ce = (v[4:3] == 2'h0) ? 1'b1 : (v[4:3] == 2'h1) ? ~v[2] : 1'b0;
      e_oe = (v[4:3] == 2'h0) ? 1'b1 : (v[1] & v[0]);
      e_ea = (v[4:3] == 2'h2);
      check("chip enable", {3'h0, e_ce}, {3'h0, ce_n});
      check("output enable", {3'h0, e_oe}, {3'h0, oe_n});
      check("external access", {3'h0, e_ea}, {3'h0, ea});
    end
  endtask
  // Core clock at 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Main sequence: reset, latches, then memory maps.
  initial begin
    {rst_n, sw_hi, sw_lo, addr, rd_n, psen_n} = 10'h003;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("indicators after reset", 4'h0, ind);
    test_latches();
    test_maps();
    complete_run();
  end
  // Cuts a hang short well beyond the expected hundred or so cycles.
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
